// ==== src/adcrc_pkg.sv ====
// Purpose: Shared constants and types of the converter control block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   Converter clock is the system clock divided by six
package adcrc_pkg;
  localparam logic [7:0] CTRL1_OFFSET = 8'hb4;
  localparam logic [7:0] CTRL2_OFFSET = 8'hb5;
  localparam logic [7:0] RESLO_OFFSET = 8'hba;
  localparam logic [7:0] RESHI_OFFSET = 8'hbb;
  localparam logic [7:0] IRQSTAT_OFFSET = 8'hbc;
  localparam logic [7:0] IRQMASK_OFFSET = 8'hbd;
  localparam logic [7:0] RNDLO_OFFSET = 8'hbe;
  localparam logic [7:0] RNDHI_OFFSET = 8'hbf;

  localparam int EOC_BIT   = 7;
  localparam int START_BIT = 6;

  localparam logic [1:0] TRIG_RESET = 2'h3;
  localparam logic [1:0] RND_RESET  = 2'h0;
  localparam logic [1:0] RSV_RESET  = 2'h3;
  localparam logic [1:0] REF_RESET  = 2'h0;
  localparam logic [1:0] DEC_RESET  = 2'h1;
  localparam logic [15:0] LFSR_RESET = 16'hffff;
  localparam logic [15:0] LFSR_TAPS  = 16'h8016;

  localparam logic [1:0] TRIG_PIN   = 2'h0;
  localparam logic [1:0] TRIG_FREE  = 2'h1;
  localparam logic [1:0] TRIG_TIMER = 2'h2;
  localparam logic [1:0] TRIG_SOFT  = 2'h3;

  localparam logic [1:0] RND_IDLE = 2'h0;
  localparam logic [1:0] RND_STEP = 2'h1;
  localparam logic [1:0] RND_OFF  = 2'h3;

  localparam int         CLK_DIV        = 6;
  localparam logic [2:0] CLK_DIV_LAST   = 3'(CLK_DIV - 1);
  localparam int         SETTLE_CYCLES  = 16;
  localparam int         DEC_BASE       = 64;

  typedef struct packed {
    logic [1:0] trigSel;
    logic [1:0] rndCtrl;
    logic [1:0] reserved;
  } adcrc_ctrl1_s;

  typedef struct packed {
    logic [1:0] refSel;
    logic [1:0] decSel;
  } adcrc_ctrl2_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } adcrc_bus_s;
endpackage

// ==== src/adcrc_conv_timer.sv ====
// Purpose: Converter clock divider and conversion length counter
// Assumes: Started only while idle
// Notes:   Counts decimation rate plus settling in converter clocks
module adcrc_conv_timer (
  input  wire logic       clk,      // System clock
  input  wire logic       nrst,     // Async reset, active low
  input  wire logic       clkEn,    // Freeze when low
  input  wire logic       start,    // Start pulse
  input  wire logic [1:0] decSel,   // Decimation select
  output logic            busy,     // Conversion running
  output logic            done      // One-cycle completion pulse
);
  logic [2:0]  divCnt_reg;
  logic [10:0] convCnt_reg;
  logic        tick;

  assign tick = (divCnt_reg == adcrc_pkg::CLK_DIV_LAST);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      divCnt_reg <= 3'h0;
    end else if (clkEn) begin
      if (start || tick) begin
        divCnt_reg <= 3'h0;
      end else begin
        divCnt_reg <= divCnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      convCnt_reg <= 11'h000;
      busy        <= 1'b0;
      done        <= 1'b0;
    end else if (clkEn) begin
      done <= 1'b0;
      if (start && !busy) begin
        // Decimation rate is 64 shifted by the select, plus settling
        convCnt_reg <= 11'((adcrc_pkg::DEC_BASE << decSel) + adcrc_pkg::SETTLE_CYCLES - 1);
        busy        <= 1'b1;
      end else if (busy && tick) begin
        if (convCnt_reg == 11'h000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          convCnt_reg <= convCnt_reg - 11'h001;
        end
      end
    end
  end
endmodule

// ==== src/adc_result_control_regs.sv ====
// Purpose: Control, result and random generator registers of the converter
// Assumes: Analog result arrives as a 14-bit two's complement word
// Notes:   Status/mask registers drive one level interrupt
// Functional notes
// - Result low shows result bits 5:0 in bits 7:2, low two bits zero.
// - Result high shows result bits 13:6 across all eight bits.
// - End flag sets on completion, clears after both result registers read.
// - A further completion before reading keeps the end flag set and forgets any register already read.
// - Start bit write launches a sequence only with software select, when idle.
// - Start bit reads one while the started conversion runs.
// - Trigger select chooses pin, free running, timer output or start bit.
// - Free running select runs sequences back to back without triggers.
// - Random generator is a 16-bit LFSR steered by control one bits 3:2.
// - Writing 01 steps the LFSR once, then the field returns to 00.
// - Value 11 stops the generator, 10 reserved, 00 idle; resets 00.
// - Reference select chooses internal, external pin, supply or differential.
// - Decimation select sets rate 64, 128, 256 or 512; resets to 01.
// - Conversion takes decimation rate plus 16 converter clocks.
// - Converter clock is the system clock divided by six.
// - Results are two's complement; single ended gives non-negative values.
module adc_result_control_regs (
  input  wire logic        clk,          // System clock, 10 MHz
  input  wire logic        nrst,         // Async reset, active low
  input  wire logic        clkEn,        // Freezes all state when low
  input  wire logic [7:0]  regAddr,      // Register address
  input  wire logic [7:0]  regWdata,     // Write data
  input  wire logic        regWr,        // Write strobe
  input  wire logic        regRd,        // Read strobe
  output logic      [7:0]  regRdata,     // Read data, cycle after strobe
  input  wire logic        extTrigPin,   // External trigger pin, async
  input  wire logic        timerOut,     // Timer channel output, same clock
  input  wire logic [13:0] analogResult, // Converter result word
  output logic [1:0]       refSelOut,    // Reference select to analog
  output logic             convBusy,     // Conversion in progress
  output logic             irq           // Level interrupt
);
  adcrc_pkg::adcrc_ctrl1_s ctrl1_reg;
  adcrc_pkg::adcrc_ctrl2_s ctrl2_reg;
  logic [13:0] result_reg;
  logic        eoc_reg;
  logic        startBit_reg;
  logic        readLo_reg;
  logic        readHi_reg;
  logic [15:0] lfsr_reg;
  logic [1:0]  irqStat_reg;
  logic [1:0]  irqMask_reg;
  logic        pinSync1_reg;
  logic        pinSync2_reg;
  logic        pinPrev_reg;
  logic        busy;
  logic        done;
  logic        startReq;
  logic        wrCtrl1;
  logic        rdLo;
  logic        rdHi;
  logic        rdStat;
  logic        rndStepped;
  logic        softStart;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign wrCtrl1 = regWr && hit(regAddr, adcrc_pkg::CTRL1_OFFSET);
  assign rdLo    = regRd && hit(regAddr, adcrc_pkg::RESLO_OFFSET);
  assign rdHi    = regRd && hit(regAddr, adcrc_pkg::RESHI_OFFSET);
  assign rdStat  = regRd && hit(regAddr, adcrc_pkg::IRQSTAT_OFFSET);

  // Pin is asynchronous: two flops before the edge detector
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinSync1_reg <= 1'b0;
      pinSync2_reg <= 1'b0;
      pinPrev_reg  <= 1'b0;
    end else if (clkEn) begin
      pinSync1_reg <= extTrigPin;
      pinSync2_reg <= pinSync1_reg;
      pinPrev_reg  <= pinSync2_reg;
    end
  end

  // Start bit counts only beside a select written as software start,
  // so one write cannot start and leave another source selected
  assign softStart = wrCtrl1 && regWdata[adcrc_pkg::START_BIT]
                     && (regWdata[5:4] == adcrc_pkg::TRIG_SOFT);

  always_comb begin
    startReq = softStart;
    unique case (ctrl1_reg.trigSel)
      adcrc_pkg::TRIG_PIN:   startReq = softStart || (pinSync2_reg && !pinPrev_reg);
      adcrc_pkg::TRIG_FREE:  startReq = 1'b1;
      adcrc_pkg::TRIG_TIMER: startReq = softStart || timerOut;
      adcrc_pkg::TRIG_SOFT:  startReq = softStart;
    endcase
  end

  adcrc_conv_timer u_timer (
    .clk    (clk),
    .nrst   (nrst),
    .clkEn  (clkEn),
    .start  (startReq && !busy),
    .decSel (ctrl2_reg.decSel),
    .busy   (busy),
    .done   (done)
  );

  // Start bit: set on an accepted software start, cleared at completion
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      startBit_reg <= 1'b0;
    end else if (clkEn) begin
      if (softStart && !busy) begin
        startBit_reg <= 1'b1;
      end else if (done) begin
        startBit_reg <= 1'b0;
      end
    end
  end

  // Two's complement word latched as delivered, left aligned on read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_reg <= 14'h0000;
    end else if (clkEn && done) begin
      result_reg <= analogResult;
    end
  end

  // End flag: completion wins over the clearing read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eoc_reg    <= 1'b0;
      readLo_reg <= 1'b0;
      readHi_reg <= 1'b0;
    end else if (clkEn) begin
      if (done) begin
        eoc_reg    <= 1'b1;
        readLo_reg <= 1'b0;
        readHi_reg <= 1'b0;
      end else if (eoc_reg) begin
        if ((rdLo || readLo_reg) && (rdHi || readHi_reg)) begin
          eoc_reg    <= 1'b0;
          readLo_reg <= 1'b0;
          readHi_reg <= 1'b0;
        end else begin
          readLo_reg <= readLo_reg || rdLo;
          readHi_reg <= readHi_reg || rdHi;
        end
      end
    end
  end

  assign rndStepped = (ctrl1_reg.rndCtrl == adcrc_pkg::RND_STEP);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_reg.trigSel  <= adcrc_pkg::TRIG_RESET;
      ctrl1_reg.rndCtrl  <= adcrc_pkg::RND_RESET;
      ctrl1_reg.reserved <= adcrc_pkg::RSV_RESET;
    end else if (clkEn) begin
      if (wrCtrl1) begin
        ctrl1_reg.trigSel  <= regWdata[5:4];
        ctrl1_reg.rndCtrl  <= regWdata[3:2];
        ctrl1_reg.reserved <= regWdata[1:0];
      end else if (rndStepped) begin
        ctrl1_reg.rndCtrl <= adcrc_pkg::RND_IDLE;
      end
    end
  end

  // LFSR steps once on the cycle the step command stands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lfsr_reg <= adcrc_pkg::LFSR_RESET;
    end else if (clkEn && rndStepped) begin
      lfsr_reg <= {lfsr_reg[14:0], ^(lfsr_reg & adcrc_pkg::LFSR_TAPS)};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl2_reg.refSel <= adcrc_pkg::REF_RESET;
      ctrl2_reg.decSel <= adcrc_pkg::DEC_RESET;
    end else if (clkEn && regWr && hit(regAddr, adcrc_pkg::CTRL2_OFFSET)) begin
      ctrl2_reg.refSel <= regWdata[7:6];
      ctrl2_reg.decSel <= regWdata[5:4];
    end
  end

  // Bit 0 completion, bit 1 start accepted; set beats read-clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStat_reg <= 2'h0;
      irqMask_reg <= 2'h0;
    end else if (clkEn) begin
      irqStat_reg <= (rdStat ? 2'h0 : irqStat_reg) | {startReq && !busy, done};
      if (regWr && hit(regAddr, adcrc_pkg::IRQMASK_OFFSET)) begin
        irqMask_reg <= regWdata[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq       <= 1'b0;
      convBusy  <= 1'b0;
      refSelOut <= adcrc_pkg::REF_RESET;
    end else if (clkEn) begin
      irq       <= |(irqStat_reg & irqMask_reg);
      convBusy  <= busy;
      refSelOut <= ctrl2_reg.refSel;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (clkEn) begin
      regRdata <= 8'h00;
      if (regRd) begin
        unique case (regAddr)
          adcrc_pkg::CTRL1_OFFSET:   regRdata <= {eoc_reg, startBit_reg, ctrl1_reg};
          adcrc_pkg::CTRL2_OFFSET:   regRdata <= {ctrl2_reg, 4'h0};
          adcrc_pkg::RESLO_OFFSET:   regRdata <= {result_reg[5:0], 2'h0};
          adcrc_pkg::RESHI_OFFSET:   regRdata <= result_reg[13:6];
          adcrc_pkg::IRQSTAT_OFFSET: regRdata <= {6'h00, irqStat_reg};
          adcrc_pkg::IRQMASK_OFFSET: regRdata <= {6'h00, irqMask_reg};
          adcrc_pkg::RNDLO_OFFSET:   regRdata <= lfsr_reg[7:0];
          adcrc_pkg::RNDHI_OFFSET:   regRdata <= lfsr_reg[15:8];
          default:                   regRdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ==== dv/adcrc_monitor.sv ====
// Purpose: Port-level assertions for the converter control block
// Assumes: clkEn held high, offset 0xb6 left unmapped
// Notes:   Attached to every instance of the top module
module adcrc_monitor (
  input wire logic       clk,       // System clock
  input wire logic       nrst,      // Async reset, active low
  input wire logic [7:0] regAddr,   // Register address
  input wire logic [7:0] regWdata,  // Write data
  input wire logic       regWr,     // Write strobe
  input wire logic       regRd,     // Read strobe
  input wire logic [7:0] regRdata,  // Read data
  input wire logic [1:0] refSelOut, // Reference select
  input wire logic       convBusy,  // Conversion running
  input wire logic       irq        // Level interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] busyCnt;

  // Busy run length, used for the minimum conversion time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busyCnt <= 12'h000;
    end else begin
      busyCnt <= convBusy ? busyCnt + 12'h001 : 12'h000;
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not zero outside a read reply");
  a_low_bits: assert property ($past(regRd && regAddr == adcrc_pkg::RESLO_OFFSET) |-> regRdata[1:0] == 2'h0)
    else $error("result low bits not zero");
  a_unmapped_zero: assert property ($past(regRd && regAddr == 8'hb6) |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_soft_start: assert property (regWr && regAddr == adcrc_pkg::CTRL1_OFFSET && regWdata[6]
    && regWdata[5:4] == adcrc_pkg::TRIG_SOFT && !convBusy && !$past(convBusy) && !$past(regWr) |-> ##2 convBusy)
    else $error("software start not launched");
  a_zero_start: assert property (regWr && regAddr == adcrc_pkg::CTRL1_OFFSET && !regWdata[6]
    && regWdata[5:4] == adcrc_pkg::TRIG_SOFT && !convBusy && !$past(convBusy) && !$past(regWr)
    |-> ##1 !convBusy [*3])
    else $error("zero start bit launched a conversion");
  a_ref_follow: assert property (regWr && regAddr == adcrc_pkg::CTRL2_OFFSET ##1
    !(regWr && regAddr == adcrc_pkg::CTRL2_OFFSET) |=> refSelOut == $past(regWdata[7:6], 2))
    else $error("reference select not following register");
  a_busy_min: assert property ($fell(convBusy) |-> busyCnt >= 12'h1d6)
    else $error("conversion shorter than minimum");
  a_irq_reset: assert property (!$past(nrst) |-> !irq)
    else $error("interrupt high right after reset");
endmodule

bind adc_result_control_regs adcrc_monitor i_mon (
  .clk       (clk),
  .nrst      (nrst),
  .regAddr   (regAddr),
  .regWdata  (regWdata),
  .regWr     (regWr),
  .regRd     (regRd),
  .regRdata  (regRdata),
  .refSelOut (refSelOut),
  .convBusy  (convBusy),
  .irq       (irq)
);

// ==== dv/tb_top.sv ====
// Purpose: Register-level bench of the converter control block
// Assumes: Result sampled on completion, status bits done and start
// Notes:   Conversion lengths checked with a small divider phase margin
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] aC1 = adcrc_pkg::CTRL1_OFFSET;
  localparam logic [7:0] aC2 = adcrc_pkg::CTRL2_OFFSET;
  logic        clk;
  logic        nrst;
  logic        clkEn;
  logic [7:0]  regAddr;
  logic [7:0]  regWdata;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdata;
  logic        extTrigPin;
  logic        timerOut;
  logic [13:0] analogResult;
  logic [1:0]  refSelOut;
  logic        convBusy;
  logic        irq;
  logic [7:0]  rv;
  logic [15:0] rnd;
  logic [15:0] rndExp;
  int          failures;
  int          n_checks;
  int          n;
  int          len;

  adc_result_control_regs i_dut (
    .clk(clk), .nrst(nrst), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .extTrigPin(extTrigPin), .timerOut(timerOut),
    .analogResult(analogResult), .refSelOut(refSelOut), .convBusy(convBusy), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(logic [15:0] seen, logic [15:0] exp, string what);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask

  // Empty name reads without comparing
  task automatic rd(logic [7:0] a, logic [7:0] exp = 8'h00, string what = "");
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    @(negedge clk);
    rv = regRdata;
    if (what != "") begin
      chk(16'(rv), 16'(exp), what);
    end
  endtask

  task automatic waitBusy(logic v);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 4000) begin
        failures++;
        summarize();
      end
    end while (convBusy !== v);
  endtask

  initial begin
    {regAddr, regWdata, regWr, regRd, extTrigPin, timerOut} = '0;
    nrst = 1'b0;
    clkEn = 1'b1;
    analogResult = 14'h2a5b;
    failures = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(aC1, 8'h33, "ctrl1 reset");
    rd(aC2, 8'h10, "ctrl2 reset");
    rd(adcrc_pkg::RESLO_OFFSET, 8'h00, "low reset");
    rd(adcrc_pkg::RESHI_OFFSET, 8'h00, "high reset");
    rd(8'hb6, 8'h00, "unmapped");
    for (int r = 0; r < 4; r++) begin
      wr(aC2, {2'(r), 6'h00});
      rd(aC2, {2'(r), 6'h00}, "ctrl2");
      chk(16'(refSelOut), 16'(r), "refSel");
    end
    wr(adcrc_pkg::IRQMASK_OFFSET, 8'h01);
    wr(aC1, 8'h63);
    repeat (4) @(negedge clk);
    chk(16'(convBusy), 16'h0, "busy timer idle");
    rd(aC1, 8'h23, "start refused");
    @(posedge clk);
    timerOut <= 1'b1;
    waitBusy(1'b1);
    @(posedge clk);
    timerOut <= 1'b0;
    waitBusy(1'b0);
    repeat (2) @(negedge clk);
    chk(16'(irq), 16'h1, "irq done");
    wr(aC1, 8'h03);
    analogResult <= 14'h1234;
    @(posedge clk);
    extTrigPin <= 1'b1;
    waitBusy(1'b1);
    @(posedge clk);
    extTrigPin <= 1'b0;
    waitBusy(1'b0);
    repeat (2) @(negedge clk);
    rd(aC1, 8'h83, "eoc kept");
    rd(adcrc_pkg::RESHI_OFFSET, 8'h48, "result high");
    rd(aC1, 8'h83, "eoc after high");
    rd(adcrc_pkg::RESLO_OFFSET, 8'hd0, "result low");
    rd(aC1, 8'h03, "eoc cleared");
    rd(adcrc_pkg::IRQSTAT_OFFSET, 8'h03, "irq status");
    repeat (2) @(negedge clk);
    chk(16'(irq), 16'h0, "irq cleared");
    wr(aC1, 8'h13);
    waitBusy(1'b1);
    waitBusy(1'b0);
    waitBusy(1'b1);
    chk(16'(n < 8), 16'h1, "free run restart");
    wr(aC1, 8'h33);
    waitBusy(1'b0);
    for (int d = 0; d < 4; d++) begin
      wr(aC2, {2'h0, 2'(d), 4'h0});
      wr(aC1, 8'h73);
      rd(aC1, 8'hf3, "start bit busy");
      waitBusy(1'b0);
      len = ((64 << d) + 16) * 6;
      chk(16'(n >= len - 2 && n <= len + 6), 16'h1, "conv length");
      rd(aC1, 8'hb3, "start bit done");
    end
    // Low then high, the other order from the first pairing
    rd(adcrc_pkg::RESLO_OFFSET, 8'hd0, "low first");
    rd(aC1, 8'hb3, "eoc after low");
    rd(adcrc_pkg::RESHI_OFFSET, 8'h48, "high second");
    rd(aC1, 8'h33, "eoc cleared again");
    wr(aC1, 8'h37);
    rd(aC1, 8'h33, "rnd step returns");
    rd(adcrc_pkg::RNDLO_OFFSET);
    rnd[7:0] = rv;
    rd(adcrc_pkg::RNDHI_OFFSET);
    rnd[15:8] = rv;
    // One step of the generator from its reset value
    rndExp = {adcrc_pkg::LFSR_RESET[14:0], ^(adcrc_pkg::LFSR_RESET & adcrc_pkg::LFSR_TAPS)};
    chk(rnd, rndExp, "lfsr one step");
    wr(aC1, 8'h3f);
    rd(aC1, 8'h3f, "rnd off");
    rd(adcrc_pkg::RNDLO_OFFSET, rnd[7:0], "lfsr off holds");
    // A write while frozen must not land
    @(posedge clk);
    clkEn <= 1'b0;
    wr(aC1, 8'h37);
    @(posedge clk);
    clkEn <= 1'b1;
    rd(aC1, 8'h3f, "frozen write ignored");
    summarize();
  end
endmodule
